/* File: design/mbt_transmitter.sv */
// Transmitter: double-buffered shared page, sequencer, lane finder,
// busy detectors and comparator. Assumes a Wishbone classic master,
// a one-cycle frame tick from local logic, and pulled-up buses.
`timescale 1ns/1ps

module mbt_transmitter (
  input wire logic clock,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic frameTick,
  input wire logic [3:0] busClk,
  input wire logic [3:0] busDataIn,
  output logic [3:0] busDataOut,
  output logic [3:0] busDataOeN,
  output logic laneAcquired
);
  // ****************************************************************
  // State and storage
  // ****************************************************************
  mbt_pkg::mbt_regs_t r_reg;
  mbt_pkg::mbt_regs_t r_next;
  logic [7:0] pageMem [0:2*mbt_pkg::PAGE_DEPTH-1];

  logic access;
  logic memHit;
  logic [7:0] cpuIdx;
  logic [7:0] curByte;
  logic [7:0] cpuByte;
  logic [3:0] rise;
  logic [3:0] fall;
  logic selRise;
  logic selFall;
  logic selData;
  logic lane_acquired;
  logic [1:0] freeLane;

  // Bus decode, one new access per request
  assign access = cyc_i & stb_i & ~r_reg.ack;
  assign memHit = (adr_i[11:10] == mbt_pkg::MEM_BASE[11:10]);
  assign cpuIdx = adr_i[9:2];

  // page bytes for drain side and processor side
  assign curByte = pageMem[{r_reg.outPage, r_reg.ptr}];
  assign cpuByte = pageMem[{~r_reg.outPage, cpuIdx}];

  // Bus clock edges from synchronised copies
  assign rise = r_reg.clkS2 & ~r_reg.clkPrev;
  assign fall = ~r_reg.clkS2 & r_reg.clkPrev;

  // clock and data selectors on chosen lane
  assign selRise = rise[r_reg.lane];
  assign selFall = fall[r_reg.lane];
  assign selData = r_reg.datS2[r_reg.lane];

  // first free lane, lowest index wins
  always_comb begin
    lane_acquired = 1'b0;
    freeLane = 2'h0;
    for (int i = mbt_pkg::BUS_COUNT - 1; i >= 0; i--) begin
      if (!r_reg.busy[i]) begin
        lane_acquired = 1'b1;
        freeLane = i[1:0];
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next = r_reg;
    r_next.clkS1 = busClk;
    r_next.clkS2 = r_reg.clkS1;
    r_next.clkPrev = r_reg.clkS2;
    r_next.datS1 = busDataIn;
    r_next.datS2 = r_reg.datS1;

    // busy detector per bus, sampled on its own clock
    for (int i = 0; i < mbt_pkg::BUS_COUNT; i++) begin
      if (rise[i]) begin
        if (!r_reg.datS2[i]) begin
          r_next.busy[i] = 1'b1;
          r_next.onesCnt[i] = 4'h0;
        end else if (r_reg.onesCnt[i] != mbt_pkg::ONES_TO_IDLE) begin
          r_next.onesCnt[i] = r_reg.onesCnt[i] + 4'h1;
          if (r_reg.onesCnt[i] == mbt_pkg::ONES_TO_IDLE - 4'h1) begin
            r_next.busy[i] = 1'b0;
          end
        end
      end
    end

    // Wishbone answer one cycle after the request
    r_next.ack = access;
    if (access && !we_i) begin
      if (memHit) begin
        r_next.rdata = {24'h000000, cpuByte};
      end else if (adr_i == mbt_pkg::STATUS_OFFSET) begin
        r_next.rdata = {16'h0000, r_reg.busy, 2'h0, r_reg.lane,
          4'h0, r_reg.state, r_reg.outPage};
      end else if (adr_i == mbt_pkg::CONTROL_OFFSET) begin
        r_next.rdata = {31'h00000000, r_reg.enable};
      end else if (adr_i == mbt_pkg::COUNTS_OFFSET) begin
        r_next.rdata = {8'h00, r_reg.ptr, r_reg.abortCnt, r_reg.msgCnt};
      end else begin
        r_next.rdata = mbt_pkg::UNMAPPED_DATA;
      end
    end
    if (access && we_i && sel_i[0] &&
        adr_i == mbt_pkg::CONTROL_OFFSET) begin
      r_next.enable = dat_i[mbt_pkg::CONTROL_ENABLE_BIT];
    end

    // Sequencer
    unique case (r_reg.state)
      mbt_pkg::ST_IDLE: begin
      end
      mbt_pkg::ST_HUNT: begin
        // zero id means the page is exhausted
        // the reserved id is never put on a bus
        if (curByte[mbt_pkg::ID_MSB:mbt_pkg::ID_LSB] ==
            mbt_pkg::END_OF_DATA_ID) begin
          r_next.state = mbt_pkg::ST_IDLE;
        // latch lane on first free bus
        end else if (lane_acquired) begin
          r_next.lane = freeLane;
          // save the message start for a rewind; pointer advances, bit counters clear
          r_next.msgStart = r_reg.ptr;
          // zero bit ahead of the page byte
          r_next.shifter = {1'b0, curByte};
          r_next.ptr = r_reg.ptr + 8'h01;
          r_next.loadIdx = 2'h0;
          r_next.bitInLoad = 4'h0;
          r_next.bitsSent = 6'h00;
          r_next.started = 1'b0;
          r_next.state = mbt_pkg::ST_SEND;
        end
      end
      mbt_pkg::ST_SEND: begin
        // compare only on falling bus clock
        // mismatch cancels and retries after a new hunt
        if (selFall && r_reg.started && selData != r_reg.txBit) begin
          r_next.txBit = 1'b1;
          r_next.started = 1'b0;
          // rewind to the message's first byte
          r_next.ptr = r_reg.msgStart;
          r_next.abortCnt = r_reg.abortCnt + 8'h01;
          r_next.state = mbt_pkg::ST_HUNT;
        end else if (selRise) begin
          if (r_reg.bitsSent == mbt_pkg::MSG_BITS) begin
            // stop shifting and hunt for the next message
            // every message gets its own hunt
            r_next.txBit = 1'b1;
            r_next.started = 1'b0;
            r_next.msgCnt = r_reg.msgCnt + 8'h01;
            r_next.state = mbt_pkg::ST_HUNT;
          end else begin
            // unloader output moves on rising edge
            r_next.txBit = r_reg.shifter[8];
            r_next.started = 1'b1;
            r_next.bitsSent = r_reg.bitsSent + 6'h01;
            // four bytes carry id, name and value
            if (r_reg.bitInLoad == mbt_pkg::LOAD_LAST_BIT &&
                r_reg.loadIdx != mbt_pkg::LAST_BYTE) begin
              r_next.shifter = {1'b0, curByte};
              r_next.ptr = r_reg.ptr + 8'h01;
              r_next.loadIdx = r_reg.loadIdx + 2'h1;
              r_next.bitInLoad = 4'h0;
            end else begin
              // empty unloader yields the final zero
              r_next.shifter = {r_reg.shifter[7:0], 1'b0};
              r_next.bitInLoad = r_reg.bitInLoad + 4'h1;
            end
          end
        end
      end
    endcase

    // frame tick swaps pages and restarts draining
    // idle until this tick hands over a page
    if (frameTick) begin
      r_next.outPage = ~r_reg.outPage;
      r_next.ptr = 8'h00;
      r_next.txBit = 1'b1;
      r_next.started = 1'b0;
      r_next.state = r_reg.enable ? mbt_pkg::ST_HUNT : mbt_pkg::ST_IDLE;
    end

    // distributor drives only the chosen lane low
    for (int i = 0; i < mbt_pkg::BUS_COUNT; i++) begin
      r_next.busOeN[i] = ~(r_next.state == mbt_pkg::ST_SEND &&
        r_next.lane == i[1:0] && !r_next.txBit);
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.state <= mbt_pkg::ST_IDLE;
      r_reg.enable <= mbt_pkg::CONTROL_ENABLE_RESET;
      r_reg.txBit <= 1'b1;
      r_reg.busOeN <= 4'hF;
      r_reg.busy <= {4{mbt_pkg::BUSY_RESET}};
      // Data synchronisers start at the idle bus level
      r_reg.datS1 <= 4'hF;
      r_reg.datS2 <= 4'hF;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge clock) begin
    if (access && we_i && memHit && sel_i[0]) begin
      pageMem[{~r_reg.outPage, cpuIdx}] <= dat_i[7:0];
    end
  end

  // Outputs
  assign dat_o = r_reg.rdata;
  assign ack_o = r_reg.ack;
  assign busDataOut = 4'h0;         // Open drain: only pulls low
  assign busDataOeN = r_reg.busOeN;
  // acquired while a message is in flight
  assign laneAcquired = (r_reg.state == mbt_pkg::ST_SEND);
endmodule // mbt_transmitter

/* File: include/mbt_pkg.sv */
// Package for the multibus serial transmitter: map, layouts, counts.
// Assumes a 50 MHz system clock and four wired-or serial buses.
package mbt_pkg;
  // ****************************************************************
  // Register map (byte addresses on Wishbone)
  // ****************************************************************
  localparam logic [11:0] MEM_BASE = 12'h000;   // Input page, 256 words
  localparam logic [11:0] STATUS_OFFSET = 12'h400;
  localparam logic [11:0] CONTROL_OFFSET = 12'h404;
  localparam logic [11:0] COUNTS_OFFSET = 12'h408;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  localparam logic CONTROL_ENABLE_RESET = 1'b0;
  localparam int CONTROL_ENABLE_BIT = 0;

  // ****************************************************************
  // Shared memory and message format
  // ****************************************************************
  localparam int PAGE_DEPTH = 256;
  localparam int PAGE_AW = 8;
  localparam int BUS_COUNT = 4;
  localparam int ID_MSB = 7;
  localparam int ID_LSB = 3;
  localparam logic [4:0] END_OF_DATA_ID = 5'h00;

  // ****************************************************************
  // Serial counts
  // ****************************************************************
  localparam logic [3:0] LOAD_LAST_BIT = 4'h8;    // Nine bits per load
  localparam logic [1:0] LAST_BYTE = 2'h3;        // Four loads
  localparam logic [5:0] MSG_BITS = 6'h25;        // 37 bits
  localparam logic [3:0] ONES_TO_IDLE = 4'h8;
  localparam logic BUSY_RESET = 1'b1;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HUNT = 3'b010,
    ST_SEND = 3'b100
  } mbt_state_t;

  // Whole state of the transmitter
  typedef struct packed {
    mbt_state_t state;
    logic enable;
    logic outPage;
    logic [7:0] ptr;
    logic [7:0] msgStart;
    logic [1:0] lane;
    logic [8:0] shifter;
    logic [3:0] bitInLoad;
    logic [1:0] loadIdx;
    logic [5:0] bitsSent;
    logic started;
    logic txBit;
    logic [3:0] busOeN;
    logic [3:0] clkS1;
    logic [3:0] clkS2;
    logic [3:0] clkPrev;
    logic [3:0] datS1;
    logic [3:0] datS2;
    logic [3:0] busy;
    logic [3:0][3:0] onesCnt;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] abortCnt;
    logic [7:0] msgCnt;
  } mbt_regs_t;
endpackage

/* File: test/mbt_bus_model.sv */
// Four wired-or serial buses with pull-ups and one shared bus clock.
// Assumes active-low open-drain enables from the transmitter.
`timescale 1ns/1ps
module mbt_bus_model (
  input wire logic [3:0] busDataOeN,
  input wire logic [3:0] jam,
  output logic [3:0] busClk,
  output logic [3:0] busDataIn
);
  logic bclk;
  // Free-running bus clock, 160 ns, unrelated phase
  initial begin
    bclk = 1'b0;
    #7;
    forever #80 bclk = ~bclk;
  end
  assign busClk = {4{bclk}};
  // jam is a contender or a failed bus pulling low
  assign busDataIn = busDataOeN & ~jam;
endmodule // mbt_bus_model

/* File: test/mbt_transmitter_assertions.sv */
// Port checker for the transmitter, bound from the testbench top.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module mbt_transmitter_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic frameTick,
  input wire logic [3:0] busClk,
  input wire logic [3:0] busDataOut,
  input wire logic [3:0] busDataOeN,
  input wire logic laneAcquired
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_reset_quiet: assert property (@(posedge clock) disable iff (1'b0)
    rst |=> busDataOeN == 4'hF && !laneAcquired && !ack_o)
    else $error("not quiet in reset");
  a_tick_stops: assert property (frameTick |=> !laneAcquired)
    else $error("send survives frame tick");
  a_quiet_idle: assert property (!laneAcquired && !$past(laneAcquired)
    |-> busDataOeN == 4'hF)
    else $error("bus driven while not sending");
  a_one_lane: assert property ($onehot0(~busDataOeN))
    else $error("more than one bus driven");
  a_open_drain: assert property (busDataOut == 4'h0)
    else $error("bus data out not zero");
  a_start_clean: assert property ($rose(laneAcquired)
    |-> busDataOeN == 4'hF)
    else $error("bus driven before first bit");
  a_rising_only: assert property ($changed(busDataOeN) && laneAcquired
    && $past(laneAcquired) |-> $past(busClk) != 4'h0)
    else $error("bit changed away from rising bus clock");
endmodule // mbt_transmitter_assertions

/* File: test/mbt_transmitter_tb_top.sv */
// Testbench: page loading, wire framing, lane choice, abort and retry.
// Assumes the package, bus model and checker are compiled first.
`timescale 1ns/1ps
module mbt_transmitter_tb_top;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, e;} mbt_row_t;
  logic clock, rst, cyc_i, stb_i, we_i, ack_o, frameTick, laneAcquired;
  logic [11:0] adr_i;
  logic [3:0] sel_i, busClk, busDataIn, busDataOut, busDataOeN, jam, low;
  logic [31:0] dat_i, dat_o, rd;
  logic [36:0] b;
  int mismatches, checked, i, n;
  mbt_row_t rows[15] = '{'{1'b1, 12'h000, 32'hA9, 32'h0},
    '{1'b1, 12'h004, 32'h3C, 32'h0}, '{1'b1, 12'h008, 32'h81, 32'h0},
    '{1'b1, 12'h00C, 32'h7E, 32'h0}, '{1'b1, 12'h010, 32'h58, 32'h0},
    '{1'b1, 12'h014, 32'h00, 32'h0}, '{1'b1, 12'h018, 32'hFF, 32'h0},
    '{1'b1, 12'h01C, 32'h01, 32'h0}, '{1'b1, 12'h020, 32'h00, 32'h0},
    '{1'b0, 12'h000, 32'h0, 32'hA9}, '{1'b0, 12'h004, 32'h0, 32'h3C},
    '{1'b1, 12'h404, 32'h1, 32'h0}, '{1'b0, 12'h404, 32'h0, 32'h1},
    '{1'b1, 12'h800, 32'h55, 32'h0}, '{1'b0, 12'h800, 32'h0, 32'h0}};
  logic [31:0] f2[5] = '{32'hFF, 32'h12, 32'h34, 32'h56, 32'h00};

  mbt_transmitter dut (.clock(clock), .rst(rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .frameTick(frameTick),
    .busClk(busClk), .busDataIn(busDataIn), .busDataOut(busDataOut),
    .busDataOeN(busDataOeN), .laneAcquired(laneAcquired));
  mbt_bus_model bus (.busDataOeN(busDataOeN), .jam(jam), .busClk(busClk),
    .busDataIn(busDataIn));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string s, input logic [36:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  // Wire image of one message: a zero ahead of each byte and at the end
  function automatic logic [36:0] msg(input logic [7:0] b1, b2, b3, b4);
    return {1'b0, b1, 1'b0, b2, 1'b0, b3, 1'b0, b4, 1'b0};
  endfunction

  // Classic cycle, held until ack is sampled; only the watchdog ends it
  task automatic wb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    {cyc_i, stb_i, we_i} <= {2'h3, w};
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge clock);
    end while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask

  task automatic tick;
    @(posedge clock);
    frameTick <= 1'b1;
    @(posedge clock);
    frameTick <= 1'b0;
  endtask

  // all 37 wire bits from the first zero on a lane
  task automatic cap(input int l, output logic [36:0] q);
    int k;
    k = 0;
    do begin
      @(negedge busClk[0]);
      k++;
    end while (busDataIn[l] !== 1'b0 && k < 2000);
    q = 37'h0;
    repeat (36) begin
      @(negedge busClk[0]);
      q = {q[35:0], busDataIn[l]};
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Watchdog: several times the expected length of the run
  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {cyc_i, stb_i, we_i, frameTick, rst} = 5'h01;
    adr_i = 12'h000;
    sel_i = 4'hF;
    dat_i = 32'h0;
    jam = 4'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("oen", 37'hF, {33'h0, busDataOeN});
    for (i = 0; i < 15; i++) begin
      wb(rows[i].w, rows[i].a, rows[i].d, rd);
      if (!rows[i].w) chk("rd", {5'h0, rows[i].e}, {5'h0, rd});
    end
    repeat (100) @(posedge clock);
    tick();
    cap(0, b);
    chk("m1", msg(8'hA9, 8'h3C, 8'h81, 8'h7E), b);
    cap(1, b);
    chk("m2", msg(8'h58, 8'h00, 8'hFF, 8'h01), b);
    repeat (400) @(posedge clock);
    chk("idle", 37'h0, {36'h0, laneAcquired});
    wb(1'b0, 12'h408, 32'h0, rd);
    chk("cnt", 37'h080002, {13'h0, rd[23:0]});
    // Lane 0 fails low well before the tick
    jam <= 4'h1;
    for (i = 0; i < 5; i++) wb(1'b1, 12'(i * 4), f2[i], rd);
    repeat (20) @(posedge clock);
    tick();
    n = 0;
    low = 4'h0;
    do begin
      @(posedge clock);
      low = low | ~busDataOeN;
      n++;
    end while (busDataOeN[1] !== 1'b0 && n < 5000);
    chk("stuck", 37'h0, {36'h0, low[0]});
    chk("lane1", 37'h0, {36'h0, busDataOeN[1]});
    repeat (2) @(negedge busClk[0]);
    @(posedge clock);
    jam <= 4'h3;
    cap(2, b);
    chk("retry", msg(8'hFF, 8'h12, 8'h34, 8'h56), b);
    jam <= 4'h0;
    repeat (20) @(posedge clock);
    wb(1'b0, 12'h408, 32'h0, rd);
    chk("cnt2", 37'h040103, {13'h0, rd[23:0]});
    // Reset in mid-run: status back to idle, page 0, all buses busy
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    wb(1'b0, 12'h400, 32'h0, rd);
    chk("status", 37'h0000F002, {5'h0, rd});
    wb(1'b0, 12'h404, 32'h0, rd);
    chk("enable", 37'h0, {5'h0, rd});
    // Disabled transmitter stays idle across a tick
    tick();
    repeat (150) @(posedge clock);
    chk("off", 37'h0, {36'h0, laneAcquired});
    chk("offoen", 37'hF, {33'h0, busDataOeN});
    close_out();
  end
endmodule // mbt_transmitter_tb_top

bind mbt_transmitter mbt_transmitter_assertions chk_i (.clock(clock),
  .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .frameTick(frameTick), .busClk(busClk), .busDataOut(busDataOut),
  .busDataOeN(busDataOeN), .laneAcquired(laneAcquired));
